// ==== verilog/eeprom_slave_pkg.sv ====
package eeprom_slave_pkg;
  localparam int ADDR_W = 11;
  localparam int PAGE_LOW_W = 5;
  localparam int PAGE_BYTES = 32;
  localparam int FIFO_DEPTH = 8;
  localparam int FIFO_WIDTH = ADDR_W + 8;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [ADDR_W-1:0] ADDR_STEP = 11'h001;
  localparam logic [PAGE_LOW_W-1:0] PAGE_STEP = 5'h01;
  localparam logic [3:0] DEV_TYPE_DEFAULT = 4'h6; // arbitrary value
  localparam int CLK_HZ = 10_000_000;
  localparam int WRITE_TIME_MS = 10;
  // longest time: rounds down to whole cycles
  localparam int WRITE_CYCLES = (CLK_HZ / 1000) * WRITE_TIME_MS;
endpackage

// ==== verilog/serial_eeprom_bus_slave.sv ====
// Operation
// - bus idle only while data and clock both stay high.
// - data falling while clock high is a start; transfers begin with it.
// - data rising while clock high is a stop; it ends the transfer.
// - data stable during clock high; changes then are start or stop.
// - one clock pulse per bit, sampled during the high phase.
// - every byte, address byte included, goes most significant bit first.
// - eight bits then a ninth acknowledge bit, clocked by the master.
// - the acknowledger holds data low through the acknowledge high phase.
// - addressed receiver acknowledges each byte unless guarded or busy.
// - after the master withholds acknowledge, release data high.
// - respond only if upper four address bits match the type code.
// - next three address bits pick a 256-byte block, top address bits.
// - address byte lowest bit: one reads, zero writes.
// - write carries address byte, word address byte, then data bytes.
// - erase/write cycle starts at the closing stop, lasts at most 10 ms; busy here holds at least WRITE_CYCLES clocks, more while the drain stalls.
// - during the erase/write cycle ignore inputs, never acknowledge.
// - write increments only low five address bits, page bits kept.
// - writes only while guard low; high means no data acknowledge.
// - under guard, address and word address bytes still acknowledged.
// - read increments full eleven-bit address, 2047 wraps to 0.
// - support current-address, random and sequential reads.
`timescale 1ns/100ps

module word_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_ce,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [PW:0] FULL_COUNT = (PW + 1)'(DEPTH);
  localparam logic [PW-1:0] LAST_PTR = PW'(DEPTH - 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wr_ptr;
  logic [PW-1:0] rd_ptr;
  logic [PW:0] count;
  wire push = i_in_valid && o_in_ready;
  wire pop = o_out_valid && i_out_ready;
  wire [PW-1:0] next_wr_ptr = (wr_ptr == LAST_PTR) ? '0 : wr_ptr + 1'b1;
  wire [PW-1:0] next_rd_ptr = (rd_ptr == LAST_PTR) ? '0 : rd_ptr + 1'b1;

  assign o_in_ready = (count != FULL_COUNT);
  assign o_out_valid = (count != '0);
  assign o_out_data = mem[rd_ptr];

  always_ff @(posedge i_clk) begin
    if (i_ce && push) begin
      mem[wr_ptr] <= i_in_data;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else if (i_ce) begin
      if (push) begin
        wr_ptr <= next_wr_ptr;
      end
      if (pop) begin
        rd_ptr <= next_rd_ptr;
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule

module serial_eeprom_bus_slave #(
  parameter logic [3:0] DEV_TYPE = eeprom_slave_pkg::DEV_TYPE_DEFAULT,
  parameter int unsigned WRITE_CYCLES = eeprom_slave_pkg::WRITE_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_ce,
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda_out,
  output logic o_sda_oe,
  input wire logic i_write_guard,
  output logic [eeprom_slave_pkg::ADDR_W-1:0] o_mem_rd_addr,
  input wire logic [7:0] i_mem_rd_data,
  output logic o_mem_wr_valid,
  input wire logic i_mem_wr_ready,
  output logic [eeprom_slave_pkg::ADDR_W-1:0] o_mem_wr_addr,
  output logic [7:0] o_mem_wr_data,
  output logic o_busy
);
  localparam int AW = eeprom_slave_pkg::ADDR_W;
  localparam int PL = eeprom_slave_pkg::PAGE_LOW_W;
  localparam int TW = $clog2(WRITE_CYCLES + 1);
  localparam logic [TW-1:0] TIMER_LOAD = TW'(WRITE_CYCLES - 1);

  typedef enum logic [3:0] {
    S_IDLE, S_ADDR, S_ACK_ADDR, S_WADDR, S_ACK_WADDR, S_WDATA, S_ACK_WDATA,
    S_RDATA, S_RACK, S_RNEXT, S_WAIT
  } bus_state_t;

  // first flop of each synchroniser feeds only the second
  logic scl_m, scl_s, scl_d;
  logic sda_m, sda_s, sda_d;
  logic guard_m, guard_s;

  bus_state_t state, next_state;
  logic [7:0] shreg, next_shreg;
  logic [3:0] bit_cnt, next_bit_cnt;
  logic [AW-1:0] addr, next_addr;
  logic rw, next_rw;
  logic oe, next_oe;
  logic page_we;
  logic stop_seen;
  logic [7:0] page_data [eeprom_slave_pkg::PAGE_BYTES];
  logic [eeprom_slave_pkg::PAGE_BYTES-1:0] page_valid;
  logic [AW-PL-1:0] page_base;
  logic [PL-1:0] drain_idx;
  logic busy;
  logic [TW-1:0] timer;
  wire scl_rise = scl_s && !scl_d;
  wire scl_fall = !scl_s && scl_d;
  wire start_det = scl_s && scl_d && !sda_s && sda_d;
  wire stop_det = scl_s && scl_d && sda_s && !sda_d;
  wire byte_done = (bit_cnt == eeprom_slave_pkg::BYTE_BITS);
  wire type_match = (shreg[7:4] == DEV_TYPE);
  wire [AW-1:0] page_next_addr = {addr[AW-1:PL], addr[PL-1:0] + eeprom_slave_pkg::PAGE_STEP};
  wire [AW-1:0] seq_next_addr = addr + eeprom_slave_pkg::ADDR_STEP;
  wire [PL-1:0] wr_idx = addr[PL-1:0];

  wire fifo_in_valid = busy && page_valid[drain_idx];
  wire fifo_in_ready;
  wire fifo_out_valid;
  wire [eeprom_slave_pkg::FIFO_WIDTH-1:0] fifo_in_data = {page_base, drain_idx,
                                                          page_data[drain_idx]};
  wire [eeprom_slave_pkg::FIFO_WIDTH-1:0] fifo_out_data;
  wire write_pending = |page_valid;
  wire cycle_done = (timer == '0) && !write_pending && !fifo_out_valid;

  assign o_sda_out = 1'b0;
  assign o_sda_oe = oe;
  assign o_busy = busy;
  assign o_mem_rd_addr = addr;
  assign o_mem_wr_valid = fifo_out_valid;
  assign o_mem_wr_addr = fifo_out_data[eeprom_slave_pkg::FIFO_WIDTH-1:8];
  assign o_mem_wr_data = fifo_out_data[7:0];

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      {scl_m, scl_s, scl_d} <= 3'h7;
      {sda_m, sda_s, sda_d} <= 3'h7;
      {guard_m, guard_s} <= 2'h3;
    end else if (i_ce) begin
      {scl_m, scl_s, scl_d} <= {i_scl, scl_m, scl_s};
      {sda_m, sda_s, sda_d} <= {i_sda, sda_m, sda_s};
      {guard_m, guard_s} <= {i_write_guard, guard_m};
    end
  end

  always_comb begin
    next_state = state;
    next_shreg = shreg;
    next_bit_cnt = bit_cnt;
    next_addr = addr;
    next_rw = rw;
    next_oe = oe;
    page_we = 1'b0;
    if (busy) begin
      next_state = S_IDLE;
      next_oe = 1'b0;
    end else if (start_det) begin
      next_state = S_ADDR;
      next_bit_cnt = '0;
      next_oe = 1'b0;
    end else if (stop_det) begin
      next_state = S_IDLE;
      next_oe = 1'b0;
    end else begin
      unique case (state)
        S_IDLE, S_WAIT: begin
        end
        S_ADDR, S_WADDR, S_WDATA: begin
          if (scl_rise) begin
            next_shreg = {shreg[6:0], sda_s};
            next_bit_cnt = bit_cnt + 1'b1;
          end else if (scl_fall && byte_done) begin
            next_bit_cnt = '0;
            if (state == S_ADDR) begin
              if (type_match) begin
                next_state = S_ACK_ADDR;
                next_oe = 1'b1;
                next_rw = shreg[0];
                next_addr = {shreg[3:1], addr[7:0]};
              end else begin
                next_state = S_WAIT;
              end
            end else if (state == S_WADDR) begin
              next_state = S_ACK_WADDR;
              next_oe = 1'b1;
              next_addr = {addr[AW-1:8], shreg};
            end else begin
              next_state = S_ACK_WDATA;
              next_oe = !guard_s;
              if (!guard_s) begin
                page_we = 1'b1;
                next_addr = page_next_addr;
              end
            end
          end
        end
        S_ACK_ADDR: begin
          if (scl_fall) begin
            if (rw) begin
              next_state = S_RDATA;
              next_shreg = i_mem_rd_data;
              next_oe = !i_mem_rd_data[7];
            end else begin
              next_state = S_WADDR;
              next_oe = 1'b0;
            end
          end
        end
        S_ACK_WADDR, S_ACK_WDATA: begin
          if (scl_fall) begin
            next_state = S_WDATA;
            next_oe = 1'b0;
          end
        end
        S_RDATA: begin
          if (scl_rise) begin
            next_bit_cnt = bit_cnt + 1'b1;
          end else if (scl_fall) begin
            if (byte_done) begin
              next_state = S_RACK;
              next_bit_cnt = '0;
              next_oe = 1'b0;
              next_addr = seq_next_addr;
            end else begin
              next_shreg = {shreg[6:0], 1'b0};
              next_oe = !shreg[6];
            end
          end
        end
        S_RACK: begin
          if (scl_rise) begin
            next_state = sda_s ? S_WAIT : S_RNEXT;
          end
        end
        S_RNEXT: begin
          if (scl_fall) begin
            next_state = S_RDATA;
            next_shreg = i_mem_rd_data;
            next_oe = !i_mem_rd_data[7];
          end
        end
        default: begin
          next_state = S_IDLE;
          next_oe = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      state <= S_IDLE;
      shreg <= '0;
      bit_cnt <= '0;
      addr <= '0;
      rw <= 1'b0;
      oe <= 1'b0;
    end else if (i_ce) begin
      state <= next_state;
      shreg <= next_shreg;
      bit_cnt <= next_bit_cnt;
      addr <= next_addr;
      rw <= next_rw;
      oe <= next_oe;
    end
  end

  // page bytes are held until the stop, so a transfer cut short by
  // a repeated start still commits at the next stop
  always_ff @(posedge i_clk) begin
    if (i_ce && page_we) begin
      page_data[wr_idx] <= shreg;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      page_valid <= '0;
      page_base <= '0;
    end else if (i_ce) begin
      if (page_we) begin
        page_valid[wr_idx] <= 1'b1;
        page_base <= addr[AW-1:PL];
      end else if (fifo_in_valid && fifo_in_ready) begin
        page_valid[drain_idx] <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      busy <= 1'b0;
      timer <= '0;
      drain_idx <= '0;
      stop_seen <= 1'b0;
    end else if (i_ce) begin
      stop_seen <= stop_det;
      if (!busy && stop_det && write_pending) begin
        busy <= 1'b1;
        timer <= TIMER_LOAD;
        drain_idx <= '0;
      end else if (busy) begin
        if (timer != '0) begin
          timer <= timer - 1'b1;
        end
        if (!page_valid[drain_idx] || fifo_in_ready) begin
          drain_idx <= drain_idx + 1'b1;
        end
        if (cycle_done) begin
          busy <= 1'b0;
        end
      end
    end
  end

  // the memory port stalls the drain; busy stretches until it empties
  word_fifo #(
    .WIDTH(eeprom_slave_pkg::FIFO_WIDTH),
    .DEPTH(eeprom_slave_pkg::FIFO_DEPTH)
  ) u_fifo (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .i_ce(i_ce),
    .i_in_valid(fifo_in_valid),
    .o_in_ready(fifo_in_ready),
    .i_in_data(fifo_in_data),
    .o_out_valid(fifo_out_valid),
    .i_out_ready(i_mem_wr_ready),
    .o_out_data(fifo_out_data)
  );

  AST_BUSY_SILENT:
  assert property (@(posedge i_clk) disable iff (i_srst) busy |-> !o_sda_oe && state == S_IDLE)
    else $error("data line driven during erase/write cycle");
  AST_DRIVE_ON_LOW_CLOCK:
  assert property (@(posedge i_clk) disable iff (i_srst) $changed(o_sda_oe) |-> !scl_d)
    else $error("data line changed while clock high");
  AST_ADDR_MATCH:
  assert property (@(posedge i_clk) disable iff (i_srst)
    (state == S_ACK_ADDR && $past(state) == S_ADDR) |-> $past(shreg[7:4]) == DEV_TYPE)
    else $error("address acknowledged without type match");
  AST_ADDR_ACK_HELD:
  assert property (@(posedge i_clk) disable iff (i_srst)
    (state == S_ACK_ADDR || state == S_ACK_WADDR) |-> o_sda_oe)
    else $error("address byte not acknowledged");
  AST_GUARD_NO_ACK:
  assert property (@(posedge i_clk) disable iff (i_srst)
    (state == S_ACK_WDATA && $past(state) == S_WDATA) |-> o_sda_oe == !$past(guard_s))
    else $error("data acknowledge disagrees with write guard");
  AST_PAGE_WRAP:
  assert property (@(posedge i_clk) disable iff (i_srst)
    page_we && i_ce |=> addr[AW-1:PL] == $past(addr[AW-1:PL])
      && addr[PL-1:0] == $past(addr[PL-1:0]) + eeprom_slave_pkg::PAGE_STEP)
    else $error("page write address step wrong");
  AST_READ_STEP:
  assert property (@(posedge i_clk) disable iff (i_srst)
    (state == S_RACK && $past(state) == S_RDATA)
      |-> addr == $past(addr) + eeprom_slave_pkg::ADDR_STEP)
    else $error("read address step wrong");
  AST_NACK_RELEASE:
  assert property (@(posedge i_clk) disable iff (i_srst)
    (state == S_RACK && scl_rise && sda_s && !start_det && !stop_det && i_ce)
      |=> !o_sda_oe && state == S_WAIT)
    else $error("data line not released after withheld acknowledge");
  AST_CYCLE_ON_STOP:
  assert property (@(posedge i_clk) disable iff (i_srst) $rose(busy) |-> stop_seen)
    else $error("erase/write cycle began without a stop");
endmodule

// ==== tb/bus_master_model.sv ====
`timescale 1ns/100ps
module bus_master_model (
  input wire logic i_clk,
  input wire logic i_sda,
  output logic o_scl,
  output logic o_sda_oe
);
  // clock stands high between frames, data line left to the pull-up
  initial begin
    o_scl = 1'b1;
    o_sda_oe = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
  endtask
  // 6 cycles low, 2 high: data moves 4 cycles after the fall so the slave's hold is met
  task automatic bit_x(input logic b, output logic r);
    tick(4);
    o_sda_oe <= ~b;
    tick(2);
    o_scl <= 1'b1;
    tick(2);
    r = i_sda;
    o_scl <= 1'b0;
  endtask
  task automatic start;
    tick(4);
    o_sda_oe <= 1'b0;
    tick(2);
    o_scl <= 1'b1;
    tick(4);
    o_sda_oe <= 1'b1;
    tick(4);
    o_scl <= 1'b0;
  endtask
  task automatic stop;
    tick(4);
    o_sda_oe <= 1'b1;
    tick(2);
    o_scl <= 1'b1;
    tick(4);
    o_sda_oe <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(d[i], r);
    bit_x(1'b1, ack);
  endtask
  task automatic rd(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(1'b1, d[i]);
    bit_x(last, r);
  endtask
endmodule

// ==== tb/serial_eeprom_bus_slave_tb_top.sv ====
`timescale 1ns/100ps
module serial_eeprom_bus_slave_tb_top;
  localparam logic [3:0] DEV = eeprom_slave_pkg::DEV_TYPE_DEFAULT;
  logic i_clk = 1'b0, i_srst = 1'b1, i_ce = 1'b1, i_write_guard = 1'b0, i_mem_wr_ready = 1'b0;
  logic scl, m_oe, o_sda_out, o_sda_oe, o_mem_wr_valid, o_busy, ack;
  logic [10:0] o_mem_rd_addr, o_mem_wr_addr;
  logic [7:0] o_mem_wr_data, mem [0:2047];
  logic [18:0] exp_q [$];
  int seed = 85406, miscompares = 0, comparisons = 0;
  wire sda = ~m_oe & (o_sda_oe ? o_sda_out : 1'b1);
  wire [7:0] rd_data = mem[o_mem_rd_addr];

  initial begin
    forever #50 i_clk = ~i_clk;
  end

  bus_master_model master (.i_clk(i_clk), .i_sda(sda), .o_scl(scl), .o_sda_oe(m_oe));
  serial_eeprom_bus_slave #(.DEV_TYPE(DEV), .WRITE_CYCLES(400)) uut (
    .i_clk(i_clk), .i_srst(i_srst), .i_ce(i_ce), .i_scl(scl), .i_sda(sda),
    .o_sda_out(o_sda_out), .o_sda_oe(o_sda_oe), .i_write_guard(i_write_guard),
    .o_mem_rd_addr(o_mem_rd_addr), .i_mem_rd_data(rd_data), .o_mem_wr_valid(o_mem_wr_valid),
    .i_mem_wr_ready(i_mem_wr_ready), .o_mem_wr_addr(o_mem_wr_addr),
    .o_mem_wr_data(o_mem_wr_data), .o_busy(o_busy));

  task automatic chk(input string what, input logic [18:0] e, input logic [18:0] g);
    comparisons++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic tally_and_finish;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // array stalls at random so the write FIFO backs up
  always @(posedge i_clk) begin
    i_mem_wr_ready <= 1'($random(seed));
    if (!i_srst && i_ce && o_mem_wr_valid && i_mem_wr_ready) begin
      chk("write", exp_q.size() != 0 ? exp_q.pop_front() : 'x,
          {o_mem_wr_addr, o_mem_wr_data});
      mem[o_mem_wr_addr] <= o_mem_wr_data;
    end
  end

  task automatic busy_wait(input logic want, input int lim);
    int n;
    n = 0;
    while (o_busy !== want && n < lim) begin
      @(posedge i_clk);
      n++;
    end
    chk("busy", {18'h0, want}, {18'h0, o_busy});
    if (o_busy !== want) tally_and_finish;
  endtask

  task automatic sel(input logic [3:0] ty, input logic [2:0] blk, input logic rw, input logic e);
    master.start();
    master.wr({ty, blk, rw}, ack);
    chk("addr ack", 19'(e), 19'(ack));
  endtask

  task automatic wpage(input logic [2:0] blk, input logic [7:0] wa, input int n, input logic g);
    logic [7:0] d;
    logic [4:0] lo;
    logic [18:0] slot [eeprom_slave_pkg::PAGE_BYTES];
    logic [eeprom_slave_pkg::PAGE_BYTES-1:0] used;
    i_write_guard <= g;
    used = '0;
    sel(DEV, blk, 1'b0, 1'b0);
    master.wr(wa, ack);
    chk("word ack", 19'h0, 19'(ack));
    lo = wa[4:0];
    for (int k = 0; k < n; k++) begin
      d = 8'($random(seed));
      slot[lo] = {blk, wa[7:5], lo, d};
      if (!g) used[lo] = 1'b1;
      master.wr(d, ack);
      chk("data ack", 19'(g), 19'(ack));
      lo = lo + eeprom_slave_pkg::PAGE_STEP;
    end
    // the page buffer commits slot by slot from the bottom, not in arrival order
    for (int s = 0; s < eeprom_slave_pkg::PAGE_BYTES; s++) begin
      if (used[s]) exp_q.push_back(slot[s]);
    end
    master.stop();
  endtask

  task automatic rseq(input logic [10:0] a, input int n, input logic rnd);
    logic [7:0] d;
    if (rnd) begin
      sel(DEV, a[10:8], 1'b0, 1'b0);
      master.wr(a[7:0], ack);
    end
    sel(DEV, a[10:8], 1'b1, 1'b0);
    for (int k = 0; k < n; k++) begin
      master.rd(k == n - 1, d);
      chk("read", {11'h0, mem[a]}, {11'h0, d});
      a = a + eeprom_slave_pkg::ADDR_STEP;
    end
    master.tick(5);
    chk("released", 19'h1, 19'(sda));
    master.stop();
  endtask

  initial begin
    for (int i = 0; i < 2048; i++) mem[i] = 8'($random(seed));
    repeat (3) @(posedge i_clk);
    i_srst <= 1'b0;
    @(posedge i_clk);
    chk("idle", 19'h0, {o_mem_rd_addr, 6'h0, o_busy, o_sda_oe});
    master.tick(4);
    // eight bytes start four below the page's top and wrap from its top back to its base
    wpage(3'h5, 8'h3C, 8, 1'b0);
    busy_wait(1'b1, 20);
    sel(DEV, 3'h5, 1'b0, 1'b1);
    master.stop();
    busy_wait(1'b0, 2000);
    chk("drain", 19'h0, 19'(exp_q.size()));
    rseq(11'h53C, 8, 1'b1);
    rseq(11'h7FE, 3, 1'b1);
    rseq(11'h301, 2, 1'b0);
    sel(~DEV, 3'h0, 1'b1, 1'b1);
    master.stop();
    wpage(3'h2, 8'h10, 2, 1'b1);
    master.tick(20);
    chk("guard busy", 19'h0, 19'(o_busy));
    wpage(3'($random(seed)), 8'($random(seed)), 3, 1'b0);
    busy_wait(1'b1, 20);
    // a frozen clock enable must stretch the busy period past its normal length
    i_ce <= 1'b0;
    master.tick(500);
    chk("frozen busy", 19'h1, 19'(o_busy));
    i_ce <= 1'b1;
    busy_wait(1'b0, 2000);
    tally_and_finish;
  end
endmodule
